// File: adcseq_core.sv
/*
 * Conversion sequencer: single-shot and continuous conversion control,
 * modulator clock division, power gating and the result register.
 * Assumes a 50 MHz clock, a host port that turns bus writes into
 * one-cycle pulses and a modulator whose bit stream is synchronous.
 */
// Overview of operation
// - Single-shot: one conversion per host request
// - Single-shot done: power down, then store result
// - Continuous: restart immediately after each conversion
// - Continuous result rate equals programmed rate
// - Result always shows latest completed conversion
// - Modulator clock is 1 MHz divided by 4
// - Filter turns bit stream into 12-bit code
// - Measure positive minus negative input
// - Mode bit 1 single-shot; reset single-shot, down
// - Start write powers up, clears flag unless a result completes that cycle, converts
// - Start during conversion is ignored
// - New settings apply after current conversion
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.svh"

module adcseq_core
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_mode_i,
    input wire logic [`ADCSEQ_RATE_W-1:0] cfg_rate_i,
    input wire logic start_i,
    input wire logic mod_bit_i,
    output logic mode_o,
    output logic [`ADCSEQ_RATE_W-1:0] output_sample_rate_o,
    output logic start_done_flag_o,
    output logic [`ADCSEQ_CODE_W-1:0] result_o,
    output logic result_new_o,
    output logic modulator_rate_o,
    output logic powered_o,
    output logic [1:0] positive_input_o,
    output logic [1:0] negative_input_o
);
    // ****************************************
    // Configuration storage
    // ****************************************
    adcseq_pkg::adcseq_state_t state_reg;
    adcseq_pkg::adcseq_state_t state_next;
    logic mode_reg;
    logic [`ADCSEQ_RATE_W-1:0] rate_reg;
    logic mode_act_reg;
    logic [`ADCSEQ_RATE_W-1:0] rate_act_reg;
    logic flag_reg;
    logic [`ADCSEQ_CODE_W-1:0] result_reg;
    logic new_reg;
    logic [7:0] div_reg;
    logic mclk_reg;
    logic [10:0] tick_cnt_reg;
    logic [11:0] pwr_cnt_reg;
    logic pwr_reg;
    logic [1:0] pos_sel_reg;
    logic [1:0] neg_sel_reg;
    logic [10:0] conv_len;
    logic mod_tick;
    logic conv_last;
    logic conv_start;
    logic pwr_done;
    logic start_ok;
    logic [`ADCSEQ_CODE_W-1:0] filt_code;
    logic filt_valid;

    // Modulator ticks per conversion; tick = 4 us so len = 250k/rate
    always_comb
    begin
        unique case (rate_act_reg)
            3'h0: conv_len = 11'd1953;
            3'h1: conv_len = 11'd1000;
            3'h2: conv_len = 11'd510;
            3'h3: conv_len = 11'd272;
            3'h4: conv_len = 11'd156;
            3'h5: conv_len = 11'd104;
            default: conv_len = 11'd76;
        endcase
    end

    assign mod_tick = (state_reg == adcseq_pkg::ADCSEQ_CONV)
        && (div_reg == 8'(`ADCSEQ_MOD_CYC - 1));
    assign conv_last = mod_tick && (tick_cnt_reg == conv_len - 11'd1);
    // Start ignored unless single-shot and idle
    assign start_ok = start_i && (state_reg == adcseq_pkg::ADCSEQ_IDLE)
        && (mode_reg == `ADCSEQ_MODE_SINGLE);
    assign pwr_done = (state_reg == adcseq_pkg::ADCSEQ_PWRUP)
        && (pwr_cnt_reg == 12'(`ADCSEQ_PWRUP_CYC - 1));
    assign conv_start = pwr_done
        || (conv_last && (mode_act_reg != `ADCSEQ_MODE_SINGLE || mode_reg != `ADCSEQ_MODE_SINGLE)
            && mode_reg != `ADCSEQ_MODE_SINGLE);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            adcseq_pkg::ADCSEQ_IDLE:
            begin
                if (start_ok || mode_reg != `ADCSEQ_MODE_SINGLE)
                begin
                    state_next = adcseq_pkg::ADCSEQ_PWRUP;
                end
            end
            adcseq_pkg::ADCSEQ_PWRUP:
            begin
                if (pwr_done)
                begin
                    state_next = adcseq_pkg::ADCSEQ_CONV;
                end
            end
            adcseq_pkg::ADCSEQ_CONV:
            begin
                if (conv_last && mode_reg == `ADCSEQ_MODE_SINGLE)
                begin
                    state_next = adcseq_pkg::ADCSEQ_IDLE;
                end
            end
            default: state_next = adcseq_pkg::ADCSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= adcseq_pkg::ADCSEQ_IDLE;
            mode_reg <= `ADCSEQ_MODE_RST;
            rate_reg <= `ADCSEQ_RATE_RST;
        end
        else
        begin
            state_reg <= state_next;
            if (cfg_wr_i)
            begin
                mode_reg <= cfg_mode_i;
                rate_reg <= cfg_rate_i;
            end
        end
    end

    // Active settings latched only at a conversion boundary
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode_act_reg <= `ADCSEQ_MODE_RST;
            rate_act_reg <= `ADCSEQ_RATE_RST;
        end
        else if (conv_start)
        begin
            mode_act_reg <= mode_reg;
            rate_act_reg <= rate_reg;
        end
    end

    // ****************************************
    // Clocks and counters
    // ****************************************
    // Divider held in idle so the modulator sees no edges
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_reg <= 8'h00;
            mclk_reg <= 1'b0;
            tick_cnt_reg <= 11'h000;
            pwr_cnt_reg <= 12'h000;
            pwr_reg <= 1'b0;
        end
        else
        begin
            div_reg <= (state_reg != adcseq_pkg::ADCSEQ_CONV || mod_tick || conv_start)
                ? 8'h00 : div_reg + 8'h01;
            mclk_reg <= (state_reg == adcseq_pkg::ADCSEQ_CONV)
                && (div_reg < 8'(`ADCSEQ_MOD_CYC / 2));
            tick_cnt_reg <= (conv_start || conv_last) ? 11'h000
                : (mod_tick ? tick_cnt_reg + 11'h001 : tick_cnt_reg);
            pwr_cnt_reg <= (state_reg == adcseq_pkg::ADCSEQ_PWRUP) ? pwr_cnt_reg + 12'h001 : 12'h000;
            pwr_reg <= (state_next != adcseq_pkg::ADCSEQ_IDLE);
        end
    end

    // ****************************************
    // Flag and result
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            flag_reg <= 1'b1;
            result_reg <= `ADCSEQ_CODE_RST;
            new_reg <= 1'b0;
        end
        else
        begin
            // Completion wins over a same-cycle start
            if (filt_valid)
            begin
                flag_reg <= 1'b1;
            end
            else if (start_ok)
            begin
                flag_reg <= 1'b0;
            end
            // Whole word in one edge; partial codes never leave the filter
            if (filt_valid)
            begin
                result_reg <= filt_code;
            end
            new_reg <= filt_valid;
        end
    end

    adcseq_filter u_filter
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(conv_start),
        .tick_i(mod_tick),
        .bit_i(mod_bit_i),
        .last_i(conv_last),
        .len_i(conv_len),
        .code_o(filt_code),
        .valid_o(filt_valid)
    );

    assign mode_o = mode_reg;
    assign output_sample_rate_o = rate_act_reg;
    assign start_done_flag_o = flag_reg;
    assign result_o = result_reg;
    assign result_new_o = new_reg;
    assign modulator_rate_o = mclk_reg;
    assign powered_o = pwr_reg;
    // Fixed routing, held in flops so every output is registered
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pos_sel_reg <= 2'h0;
            neg_sel_reg <= 2'h1;
        end
        else
        begin
            pos_sel_reg <= pos_sel_reg;
            neg_sel_reg <= neg_sel_reg;
        end
    end

    assign positive_input_o = pos_sel_reg;
    assign negative_input_o = neg_sel_reg;

    // ****************************************
    // Checks
    // ****************************************
    AST_IGNORE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (start_i && state_reg == adcseq_pkg::ADCSEQ_CONV && !conv_last)
        |=> state_reg == adcseq_pkg::ADCSEQ_CONV)
        else $error("start restarted a running conversion");
    AST_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (start_ok && !filt_valid) |=> !flag_reg && state_reg == adcseq_pkg::ADCSEQ_PWRUP)
        else $error("start did not clear flag");
    AST_SINGLE_END: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (conv_last && mode_reg) |=> state_reg == adcseq_pkg::ADCSEQ_IDLE ##1 flag_reg)
        else $error("single-shot did not end");
    AST_CONT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (conv_last && !mode_reg) |=> state_reg == adcseq_pkg::ADCSEQ_CONV && tick_cnt_reg == 11'h000)
        else $error("continuous gap");
    AST_RESULT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !filt_valid |=> $stable(result_reg))
        else $error("result changed without completion");
    AST_IDLE_CLK: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == adcseq_pkg::ADCSEQ_IDLE |=> !mclk_reg)
        else $error("modulator clocked in idle");
    AST_NO_SELF: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg == adcseq_pkg::ADCSEQ_IDLE && mode_reg && !start_i)
        |=> state_reg == adcseq_pkg::ADCSEQ_IDLE)
        else $error("self-started conversion");
    AST_SETTINGS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg == adcseq_pkg::ADCSEQ_CONV && !conv_start) |=> $stable(rate_act_reg))
        else $error("rate changed mid conversion");
    COV_SINGLE: cover property (@(posedge clk_i) disable iff (!rstn_i)
        pwr_done ##1 state_reg == adcseq_pkg::ADCSEQ_CONV);
    COV_DONE: cover property (@(posedge clk_i) disable iff (!rstn_i) filt_valid && mode_reg);
    COV_BACK: cover property (@(posedge clk_i) disable iff (!rstn_i) conv_last && !mode_reg);
endmodule
`default_nettype wire

// File: adcseq_map.svh
/*
 * Constants of the conversion sequencer: timing counts, rate table
 * indices, code widths and reset values.
 * Assumes a 50 MHz system clock and is included by its bare name.
 */
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define ADCSEQ_CLK_MHZ 50
`define ADCSEQ_OSC_KHZ 1000
`define ADCSEQ_OSC_DIV 4
`define ADCSEQ_MOD_KHZ 250
// One oscillator tick in system cycles: 50 MHz / 1 MHz
`define ADCSEQ_OSC_CYC ((`ADCSEQ_CLK_MHZ * 1000) / `ADCSEQ_OSC_KHZ)
// Modulator tick in system cycles
`define ADCSEQ_MOD_CYC (`ADCSEQ_OSC_CYC * `ADCSEQ_OSC_DIV)
`define ADCSEQ_PWRUP_US 25
`define ADCSEQ_PWRUP_CYC (`ADCSEQ_PWRUP_US * `ADCSEQ_CLK_MHZ)

// ****************************************
// Rate selection and codes
// ****************************************
`define ADCSEQ_RATE_W 3
`define ADCSEQ_CODE_W 12
`define ADCSEQ_MODE_SINGLE 1'b1
`define ADCSEQ_MODE_RST 1'b1
`define ADCSEQ_RATE_RST 3'h4
`define ADCSEQ_CODE_RST 12'h000

`endif

// File: adcseq_pkg.sv
/*
 * Types shared by the conversion sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package adcseq_pkg;
    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b00,
        ADCSEQ_PWRUP = 2'b01,
        ADCSEQ_CONV = 2'b10
    } adcseq_state_t;
endpackage
`default_nettype wire

// File: adcseq_filter.sv
/*
 * Decimating filter: counts ones of the modulator bit stream over one
 * conversion and scales the count to a 12-bit two's complement code.
 * Assumes the sequencer frames each conversion with start and last.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.svh"

module adcseq_filter
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic bit_i,
    input wire logic last_i,
    input wire logic [10:0] len_i,
    output logic [`ADCSEQ_CODE_W-1:0] code_o,
    output logic valid_o
);
    logic [10:0] ones_reg;
    logic [10:0] ones_next;
    logic [10:0] ones_sum;
    logic [`ADCSEQ_CODE_W-1:0] code_reg;
    logic valid_reg;
    logic [23:0] scaled;
    logic [11:0] unipolar;

    // Count of ones over the window
    // Sum keeps the last tick even when a back-to-back start clears the count
    assign ones_sum = tick_i ? ones_reg + {10'h000, bit_i} : ones_reg;
    assign ones_next = start_i ? 11'h000 : ones_sum;
    // Ones fraction to 12 bits, offset binary to two's complement
    assign scaled = ({13'h0000, ones_sum} << 12) / {13'h0000, len_i};
    assign unipolar = (scaled > 24'h000FFF) ? 12'hFFF : scaled[11:0];

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ones_reg <= 11'h000;
            code_reg <= `ADCSEQ_CODE_RST;
            valid_reg <= 1'b0;
        end
        else
        begin
            ones_reg <= ones_next;
            valid_reg <= last_i;
            if (last_i)
            begin
                code_reg <= {~unipolar[11], unipolar[10:0]};
            end
        end
    end

    assign code_o = code_reg;
    assign valid_o = valid_reg;
endmodule
`default_nettype wire

// File: adcseq_host_model.sv
/*
 * Host-side model: turns configuration writes and start requests into
 * the one-cycle pulses that the sequencer takes.
 * Assumes a free-running clock; the bench calls its tasks.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.svh"

module adcseq_host_model
(
    input wire logic clk_i,
    output logic cfg_wr_o,
    output logic cfg_mode_o,
    output logic [`ADCSEQ_RATE_W-1:0] cfg_rate_o,
    output logic start_o
);
    // ****************************************
    // Request tasks
    // ****************************************
    initial
    begin
        cfg_wr_o = 1'b0;
        cfg_mode_o = 1'b0;
        cfg_rate_o = 3'h0;
        start_o = 1'b0;
    end

    // Data show the inverse outside a write, so a stale sample is caught
    task automatic write_cfg(input logic mode, input logic [`ADCSEQ_RATE_W-1:0] rate);
        @(posedge clk_i);
        cfg_wr_o <= 1'b1;
        cfg_mode_o <= mode;
        cfg_rate_o <= rate;
        @(posedge clk_i);
        cfg_wr_o <= 1'b0;
        cfg_mode_o <= ~mode;
        cfg_rate_o <= ~rate;
    endtask

    task automatic request_start;
        @(posedge clk_i);
        start_o <= 1'b1;
        @(posedge clk_i);
        start_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes adcseq_core, the host model and a 50 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.svh"

module tb;
    // ****************************************
    // Clock, wiring and bookkeeping
    // ****************************************
    localparam int MOD = `ADCSEQ_MOD_CYC;
    localparam int CONV6 = 76 * MOD;
    localparam int CONV5 = 104 * MOD;
    localparam int CONV4 = 156 * MOD;
    // First shot runs at the reset rate index
    localparam int SHOT = `ADCSEQ_PWRUP_CYC + CONV4;
    // Whole run needs about 85k cycles
    localparam int LIMIT = 98000;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic mb = 1'b0;
    logic wr;
    logic md;
    logic [`ADCSEQ_RATE_W-1:0] rt;
    logic st;
    logic mode;
    logic [`ADCSEQ_RATE_W-1:0] rate;
    logic flag;
    logic [`ADCSEQ_CODE_W-1:0] res;
    logic rnew;
    logic mclk;
    logic pwr;
    logic [1:0] pin;
    logic [1:0] nin;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    always #10 clk_i = ~clk_i;

    adcseq_core u_adcseq_core (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_wr_i(wr),
        .cfg_mode_i(md), .cfg_rate_i(rt), .start_i(st), .mod_bit_i(mb),
        .mode_o(mode), .output_sample_rate_o(rate), .start_done_flag_o(flag),
        .result_o(res), .result_new_o(rnew), .modulator_rate_o(mclk),
        .powered_o(pwr), .positive_input_o(pin), .negative_input_o(nin));

    adcseq_host_model u_adcseq_host_model (.clk_i(clk_i), .cfg_wr_o(wr),
        .cfg_mode_o(md), .cfg_rate_o(rt), .start_o(st));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic wait_new(output int at);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        while (rnew !== 1'b1 && n < 40000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check(16'(rnew), 16'h1);
        at = cyc;
    endtask

    task automatic mod_period(output int per);
        int n;
        int ta;
        logic prev;
        n = 0;
        ta = 0;
        per = 0;
        prev = mclk;
        while (n < 1000 && per == 0)
        begin
            @(posedge clk_i);
            #1;
            n++;
            if (mclk === 1'b1 && prev === 1'b0)
            begin
                if (ta != 0)
                    per = cyc - ta;
                else
                    ta = cyc;
            end
            prev = mclk;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_reset;
        #1;
        check(16'(mode), 16'h1);
        check(16'(rate), 16'(`ADCSEQ_RATE_RST));
        check(16'(flag), 16'h1);
        check(16'(res), 16'h0);
        check(16'(pwr), 16'h0);
        check(16'(mclk), 16'h0);
        check(16'(pin), 16'h0);
        check(16'(nin), 16'h1);
    endtask

    task automatic s_single;
        int t0;
        int t1;
        int bad;
        logic [`ADCSEQ_CODE_W-1:0] r;
        @(posedge clk_i);
        mb <= 1'b1;
        u_adcseq_host_model.request_start();
        #1;
        t0 = cyc;
        check(16'(flag), 16'h0);
        check(16'(pwr), 16'h1);
        check(16'(rate), 16'h4);
        repeat (2000) @(posedge clk_i);
        u_adcseq_host_model.request_start();
        wait_new(t1);
        check(16'((t1 - t0) >= SHOT && (t1 - t0) <= SHOT + 4), 16'h1);
        check(16'(res), 16'h7FF);
        check(16'(flag), 16'h1);
        check(16'(pwr), 16'h0);
        r = res;
        bad = 0;
        repeat (400)
        begin
            @(posedge clk_i);
            #1;
            if (rnew !== 1'b0 || mclk !== 1'b0 || pwr !== 1'b0 || res !== r)
                bad++;
        end
        check(16'(bad), 16'h0);
    endtask

    task automatic s_cont;
        int t1;
        int t2;
        int t3;
        int per;
        logic [`ADCSEQ_CODE_W-1:0] r;
        @(posedge clk_i);
        mb <= 1'b0;
        u_adcseq_host_model.write_cfg(1'b0, 3'h6);
        u_adcseq_host_model.request_start();
        #1;
        check(16'(mode), 16'h0);
        wait_new(t1);
        r = res;
        check(16'(r), 16'h800);
        @(posedge clk_i);
        mb <= 1'b1;
        mod_period(per);
        check(16'(per), 16'(MOD));
        u_adcseq_host_model.write_cfg(1'b0, 3'h5);
        repeat (2) @(posedge clk_i);
        #1;
        check(16'(rate), 16'h6);
        check(16'(res), 16'(r));
        wait_new(t2);
        check(16'(t2 - t1), 16'(CONV6));
        check(16'(res), 16'h7FF);
        repeat (2) @(posedge clk_i);
        #1;
        check(16'(rate), 16'h5);
        @(posedge clk_i);
        mb <= 1'b0;
        u_adcseq_host_model.write_cfg(1'b1, 3'h5);
        wait_new(t3);
        check(16'(t3 - t2), 16'(CONV5));
        check(16'(res), 16'h800);
        repeat (2) @(posedge clk_i);
        #1;
        check(16'({flag, pwr, mclk}), 16'h4);
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        s_reset();
        @(posedge clk_i);
        rstn_i <= 1'b1;
        s_single();
        s_cont();
        report_and_stop();
    end
endmodule
`default_nettype wire
